// *** rdtc_ctrl.sv ***
// descriptor-driven transfer controller with apb register slave
`timescale 1ns/10ps
`default_nettype none
`include "rdtc_regs.svh"
module rdtc_ctrl
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// memory master
	output logic mem_req,
	output logic mem_we,
	output logic [1:0] mem_size,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	// activation sources and results
	input wire logic [27:0] src_irq,
	input wire logic nmi_abort,
	output logic [27:0] src_flag_clear,
	output logic [27:0] cpu_irq_req,
	output logic sw_end_irq
);
	rdtc_pkg::rdtc_regs_t s, n;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [4:0] lowest(input logic [27:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 27; i >= 0; i--)
		begin
			if (v[i])
				r = i[4:0];
		end
		return r;
	endfunction

	function automatic logic [31:0] step(input logic [31:0] a,
		input logic [1:0] am, input logic [1:0] sz);
		logic [31:0] inc;
		inc = (sz == 2'h0) ? 32'h1 : (sz == 2'h1) ? 32'h2 : 32'h4;
		case (am)
			2'h2: return a + inc;
			2'h3: return a - inc;
			default: return a;
		endcase
	endfunction

	function automatic logic misal(input logic [31:0] a, input logic [1:0] sz);
		return (sz == 2'h1 && a[0]) || (sz[1] && a[1:0] != 2'h0);
	endfunction

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	logic acc, wr_done, rd_done, done, ae_set, busy_end;
	logic [27:0] pend;
	logic [31:0] vaddr, maddr, mwdata, nsar, ndar;
	logic [7:0] rbyte;
	logic [1:0] r;

	always_comb
	begin
		n = s;
		ae_set = 1'b0;
		busy_end = 1'b0;
		vaddr = 32'h0;
		maddr = 32'h0;
		mwdata = 32'h0;
		nsar = 32'h0;
		ndar = 32'h0;
		rbyte = 8'h00;
		r = 2'h0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		n.flag_clr = 28'h0;
		// no mask level or priority input exists: activation is unconditional
		n.cpu_irq = src_irq & ~s.en; // see RQ9, RQ11
		// a source whose flag clear is in flight is not taken again
		pend = src_irq & s.en & ~s.flag_clr;
		done = s.mem_req && mem_ack;
		case (s.st)
			rdtc_pkg::RDTC_IDLE:
			begin
				if (pend != 28'h0)
				begin
					n.idx = lowest(pend); // see RQ12
					n.sw_act = 1'b0;
					vaddr = `RDTC_VEC_BASE + {26'h0, n.idx, 1'b0}; // see RQ18
					n.st = rdtc_pkg::RDTC_VEC;
				end
				else if (s.swact && !s.sw_end)
				begin
					n.sw_act = 1'b1;
					vaddr = `RDTC_VEC_BASE + {24'h0, s.vec}; // see RQ16
					n.st = rdtc_pkg::RDTC_VEC;
				end
				n.vsel = vaddr[1];
				n.ptr = {vaddr[31:2], 2'h0};
			end
			rdtc_pkg::RDTC_VEC:
			begin
				if (done)
				begin
					n.mem_req = 1'b0;
					// see RQ13
					n.ptr = {s.base, s.vsel ? mem_rdata[15:0] : mem_rdata[31:16]};
					if (n.ptr[1:0] != 2'h0)
					begin
						ae_set = 1'b1;
						n.st = rdtc_pkg::RDTC_IDLE;
					end
					else
						n.st = rdtc_pkg::RDTC_D0; // see RQ17
				end
			end
			rdtc_pkg::RDTC_D0:
			begin
				if (done)
				begin
					n.mem_req = 1'b0;
					n.mode = mem_rdata[31:16]; // see RQ1, RQ14
					n.cnt_a = mem_rdata[15:0];
					n.st = rdtc_pkg::RDTC_D1;
				end
			end
			rdtc_pkg::RDTC_D1:
			begin
				if (done)
				begin
					n.mem_req = 1'b0;
					// spare bytes ride along unused; see RQ14, RQ15
					n.word1 = mem_rdata;
					n.st = rdtc_pkg::RDTC_D2;
				end
			end
			rdtc_pkg::RDTC_D2:
			begin
				if (done)
				begin
					n.mem_req = 1'b0;
					n.sar = mem_rdata;
					n.st = rdtc_pkg::RDTC_D3;
				end
			end
			rdtc_pkg::RDTC_D3:
			begin
				if (done)
				begin
					n.mem_req = 1'b0;
					n.dar = mem_rdata;
					n.blk_cnt = s.word1[15:0]; // see RQ8
					n.blk_start = s.mode[`RDTC_MD_DTS] ? s.sar : mem_rdata;
					n.st = rdtc_pkg::RDTC_RD;
				end
			end
			rdtc_pkg::RDTC_RD:
			begin
				if (done)
				begin
					n.mem_req = 1'b0;
					n.data = mem_rdata;
					n.st = rdtc_pkg::RDTC_WR;
				end
			end
			rdtc_pkg::RDTC_WR:
			begin
				if (done)
				begin
					n.mem_req = 1'b0;
					nsar = step(s.sar, s.mode[`RDTC_MD_SM], s.mode[`RDTC_MD_SZ]);
					ndar = step(s.dar, s.mode[`RDTC_MD_DM], s.mode[`RDTC_MD_SZ]);
					n.st = rdtc_pkg::RDTC_WB0;
					n.want_irq = s.mode[`RDTC_MD_PER_TRANSFER_IRQ_SELECT]; // see RQ24
					case (s.mode[`RDTC_MD_MODE])
						rdtc_pkg::RDTC_REPEAT:
						begin
							if (s.cnt_a[7:0] == 8'h01)
							begin
								n.cnt_a[7:0] = s.cnt_a[15:8]; // see RQ6
								if (s.mode[`RDTC_MD_DTS])
									nsar = s.word1; // see RQ4
								else
									ndar = s.word1; // see RQ4
							end
							else
								n.cnt_a[7:0] = s.cnt_a[7:0] - 8'h01; // see RQ6
						end
						rdtc_pkg::RDTC_BLOCK:
						begin
							n.blk_cnt = s.blk_cnt - 16'h0001; // see RQ8
							if (s.blk_cnt == 16'h0001)
							begin
								n.cnt_a = s.cnt_a - 16'h0001; // see RQ7
								n.want_irq = s.mode[`RDTC_MD_PER_TRANSFER_IRQ_SELECT] ||
									s.cnt_a == 16'h0001;
								if (s.mode[`RDTC_MD_DTS])
									nsar = s.blk_start;
								else
									ndar = s.blk_start;
							end
							else
								n.st = rdtc_pkg::RDTC_RD;
						end
						default:
						begin
							n.cnt_a = s.cnt_a - 16'h0001; // see RQ5
							n.want_irq = s.mode[`RDTC_MD_PER_TRANSFER_IRQ_SELECT] ||
								s.cnt_a == 16'h0001; // see RQ24
						end
					endcase
					n.sar = nsar;
					n.dar = ndar;
				end
			end
			rdtc_pkg::RDTC_WB0, rdtc_pkg::RDTC_WB1, rdtc_pkg::RDTC_WB2:
			begin
				if (done)
				begin
					n.mem_req = 1'b0;
					n.st = rdtc_pkg::rdtc_state_t'({s.st[11:0], 1'b0});
				end
			end
			rdtc_pkg::RDTC_WB3:
			begin
				if (done)
				begin
					n.mem_req = 1'b0;
					if (s.mode[`RDTC_MD_CHAIN_ENABLE])
					begin
						n.ptr = s.ptr + `RDTC_DESC_STEP; // see RQ23
						n.st = rdtc_pkg::RDTC_D0;
					end
					else
						n.st = rdtc_pkg::RDTC_FIN;
				end
			end
			rdtc_pkg::RDTC_FIN:
			begin
				busy_end = 1'b1;
				n.st = rdtc_pkg::RDTC_IDLE;
				// only the last descriptor of a chain decides; see RQ10
				if (s.want_irq)
				begin
					if (s.sw_act)
						n.sw_end = 1'b1;
					else
						n.en[s.idx] = 1'b0;
				end
				else if (s.sw_act)
					n.swact = 1'b0;
				else
					n.flag_clr[s.idx] = 1'b1;
			end
			default: n.st = rdtc_pkg::RDTC_IDLE;
		endcase

		// ------------------------------------------------------------------
		// memory request issue, one state one access
		// ------------------------------------------------------------------
		case (s.st)
			rdtc_pkg::RDTC_VEC: maddr = s.ptr;
			rdtc_pkg::RDTC_D0: maddr = s.ptr;
			rdtc_pkg::RDTC_D1: maddr = s.ptr + 32'h4;
			rdtc_pkg::RDTC_D2: maddr = s.ptr + 32'h8;
			rdtc_pkg::RDTC_D3: maddr = s.ptr + 32'hc;
			rdtc_pkg::RDTC_RD: maddr = s.sar;
			rdtc_pkg::RDTC_WR: maddr = s.dar;
			rdtc_pkg::RDTC_WB0: maddr = s.ptr;
			rdtc_pkg::RDTC_WB1: maddr = s.ptr + 32'h4;
			rdtc_pkg::RDTC_WB2: maddr = s.ptr + 32'h8;
			rdtc_pkg::RDTC_WB3: maddr = s.ptr + 32'hc;
			default: maddr = 32'h0;
		endcase
		case (s.st)
			rdtc_pkg::RDTC_WR: mwdata = s.data;
			rdtc_pkg::RDTC_WB0: mwdata = {s.mode, s.cnt_a};
			rdtc_pkg::RDTC_WB1: mwdata = s.word1;
			rdtc_pkg::RDTC_WB2: mwdata = s.sar;
			rdtc_pkg::RDTC_WB3: mwdata = s.dar;
			default: mwdata = 32'h0;
		endcase
		if (!s.mem_req && !s.st[0] && !s.st[12] && n.st == s.st)
		begin
			if (s.st == rdtc_pkg::RDTC_RD &&
				(misal(s.sar, s.mode[`RDTC_MD_SZ]) ||
				misal(s.dar, s.mode[`RDTC_MD_SZ])))
			begin
				ae_set = 1'b1;
				n.st = rdtc_pkg::RDTC_IDLE;
			end
			else
			begin
				n.mem_req = 1'b1;
				n.mem_addr = maddr;
				n.mem_wdata = mwdata;
				n.mem_we = s.st[7] | s.st[8] | s.st[9] | s.st[10] | s.st[11];
				n.mem_size = (s.st[6] | s.st[7]) ? s.mode[`RDTC_MD_SZ] : 2'h2;
			end
		end
		// abort waits for any open access so the bus handshake stays whole
		if (nmi_abort && !s.st[0] && (!s.mem_req || mem_ack))
		begin
			n.mem_req = 1'b0;
			n.st = rdtc_pkg::RDTC_IDLE;
		end

		// ------------------------------------------------------------------
		// apb slave: answers one cycle into the access phase
		// ------------------------------------------------------------------
		acc = psel && penable && !s.pready;
		wr_done = psel && penable && s.pready && pwrite;
		rd_done = psel && penable && s.pready && !pwrite;
		if (acc)
		begin
			n.pready = 1'b1;
			n.prdata = 32'h0;
			case (paddr)
				`RDTC_OFS_EN_A, `RDTC_OFS_EN_B, `RDTC_OFS_EN_C, `RDTC_OFS_EN_D:
				begin
					r = paddr[3:2];
					for (int b = 0; b < 8; b++)
					begin
						if (r * 8 + b < rdtc_pkg::NSRC)
							rbyte[7 - b] = s.en[r * 8 + b]; // see RQ18
					end
					n.prdata = {24'h0, rbyte};
				end
				`RDTC_OFS_CSR:
					n.prdata = {21'h0, s.nmi_abort_flag, s.ae, s.swact, s.vec};
				`RDTC_OFS_BASE: n.prdata = {16'h0, s.base};
				default: n.pslverr = 1'b1; // see RQ2
			endcase
		end
		if (rd_done && paddr == `RDTC_OFS_CSR)
		begin
			n.nmi_abort_flag_seen = s.nmi_abort_flag_seen | s.nmi_abort_flag;
			n.ae_seen = s.ae_seen | s.ae;
			n.swact_seen = s.swact_seen | s.swact;
		end
		if (wr_done)
		begin
			case (paddr)
				`RDTC_OFS_EN_A, `RDTC_OFS_EN_B, `RDTC_OFS_EN_C, `RDTC_OFS_EN_D:
				begin
					r = paddr[3:2];
					for (int b = 0; b < 8; b++)
					begin
						if (r * 8 + b < rdtc_pkg::NSRC)
							n.en[r * 8 + b] = pwdata[7 - b]; // see RQ18
					end
				end
				`RDTC_OFS_CSR:
				begin
					n.vec = pwdata[7:0];
					if (pwdata[`RDTC_CSR_SWACT])
						n.swact = 1'b1; // see RQ20
					else if (s.swact_seen)
						n.swact = 1'b0; // see RQ20
					if (!pwdata[`RDTC_CSR_AE] && s.ae_seen)
						n.ae = 1'b0; // see RQ19
					if (!pwdata[`RDTC_CSR_NMI_ABORT_FLAG] && s.nmi_abort_flag_seen)
						n.nmi_abort_flag = 1'b0; // see RQ19
				end
				`RDTC_OFS_BASE: n.base = pwdata[15:0];
				default: n.base = s.base;
			endcase
		end
		// hardware sets win over a clear in the same cycle
		if (ae_set)
			n.ae = 1'b1;
		if (nmi_abort)
			n.nmi_abort_flag = 1'b1;
		if (!n.ae)
			n.ae_seen = 1'b0;
		if (!n.nmi_abort_flag)
			n.nmi_abort_flag_seen = 1'b0;
		if (!n.swact)
		begin
			n.swact_seen = 1'b0;
			n.sw_end = 1'b0;
		end
		if (busy_end && s.sw_act && s.want_irq)
			n.sw_end = 1'b1;
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
			s.st <= rdtc_pkg::RDTC_IDLE;
			s.en <= `RDTC_EN_RST;
			s.base <= `RDTC_BASE_RST;
		end
		else
			s <= n;
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign mem_req = s.mem_req;
	assign mem_we = s.mem_we;
	assign mem_size = s.mem_size;
	assign mem_addr = s.mem_addr;
	assign mem_wdata = s.mem_wdata;
	assign src_flag_clear = s.flag_clr;
	assign cpu_irq_req = s.cpu_irq;
	assign sw_end_irq = s.sw_end;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> // see RQ1
		mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("memory request dropped or changed before ack");
	AST_ROUTE: assert property (##1 cpu_irq_req == // see RQ9
		$past(src_irq & ~s.en))
		else $error("request routing does not follow enable bits");
	AST_PRIO: assert property (s.st == rdtc_pkg::RDTC_IDLE && // see RQ12
		(src_irq & s.en & ~s.flag_clr) != 28'h0 |=>
		s.idx == lowest($past(src_irq & s.en & ~s.flag_clr)))
		else $error("source taken out of priority order");
	AST_DESC_BASE: assert property (s.st == rdtc_pkg::RDTC_VEC && // see RQ13
		mem_ack && s.mem_req ##1 s.st == rdtc_pkg::RDTC_D0 ##1 mem_req |->
		mem_addr[31:16] == s.base)
		else $error("descriptor address not built from base");
	AST_SW_VEC: assert property (s.st == rdtc_pkg::RDTC_IDLE && // see RQ16
		s.swact && !s.sw_end && (src_irq & s.en & ~s.flag_clr) == 28'h0
		##1 1'b1 ##1 1'b1 |-> mem_addr == ($past(`RDTC_VEC_BASE +
		{24'h0, s.vec}, 2) & 32'hfffffffc))
		else $error("software vector address wrong");
	AST_FLAG_ONE: assert property ($onehot0(src_flag_clear)) // see RQ10
		else $error("more than one source flag cleared");
	AST_CNT_NORM: assert property (s.st == rdtc_pkg::RDTC_WR && // see RQ5
		mem_ack && s.mem_req && s.mode[11:10] == 2'h0 |=>
		s.cnt_a == $past(s.cnt_a) - 16'h0001)
		else $error("normal count not decremented by one");
	AST_NMI_ABORT_FLAG_HOLD: assert property (s.nmi_abort_flag && !(wr_done && // see RQ19
		paddr == `RDTC_OFS_CSR) |=> s.nmi_abort_flag)
		else $error("abort flag cleared without software write");
	AST_AE_WR1: assert property (!s.ae && !ae_set && wr_done && // see RQ19
		paddr == `RDTC_OFS_CSR |=> !s.ae)
		else $error("writing one set the address error flag");
	AST_SWACT_SET: assert property (wr_done && // see RQ20
		paddr == `RDTC_OFS_CSR && pwdata[8] |=> s.swact)
		else $error("software activate write of one lost");
	AST_APB_ANS: assert property (psel && penable |-> ##[0:1] pready)
		else $error("apb access not answered in one cycle");

	COV_SW: cover property (s.st == rdtc_pkg::RDTC_FIN && s.sw_act);
	COV_CHAIN: cover property (s.st == rdtc_pkg::RDTC_WB3 && mem_ack &&
		s.mode[`RDTC_MD_CHAIN_ENABLE]);
	COV_BLOCK: cover property (s.st == rdtc_pkg::RDTC_WR && mem_ack &&
		s.mode[11:10] == 2'h2 && s.blk_cnt == 16'h0001);
	COV_AE: cover property (ae_set);
endmodule
`default_nettype wire

// *** rdtc_regs.svh ***
// register offsets, field positions, reset values and memory layout constants
// ----------------------------------------------------------------------
// Summary of operation
// RQ1: on activation load descriptor from ram, transfer, write updated copy back.
// RQ2: working descriptor registers are hidden from software; only ram copy reaches them.
// RQ3: software gives aligned 32-bit source and destination addresses.
// RQ4: repeat area restart address is source when side select is 1, else destination.
// RQ5: normal mode count a counts down per transfer; 0 means 65536.
// RQ6: repeat mode high byte keeps count, low byte counts down; 0 means 256.
// RQ7: block mode count a counts blocks; 0 means 65536 blocks.
// RQ8: count b is the block length; 0 means 65536 units.
// RQ9: enable bit set routes source request here, clear routes it to the cpu.
// RQ10: at activation end clear the source flag or its enable bit.
// RQ11: activation ignores cpu mask level and interrupt controller priorities.
// RQ12: pending sources are served in fixed order, lowest vector first.
// RQ13: descriptor address is base register above a 16-bit vector entry.
// RQ14: normal layout mode,count a,4 spare,source,dest; repeat puts initial there.
// RQ15: block layout mode,count a,2 spare,count b,source,dest; spare bytes ignored.
// RQ16: software vector address is 0x400 plus the 8-bit software vector number.
// RQ17: software aligns descriptors to four bytes; vector read first, then descriptor.
// RQ18: each source has fixed vector in 2-byte steps and enable bit from bit 7 down.
// RQ19: abort and address error flags clear only by 0 after read as 1.
// RQ20: software activate bit takes 1 always, 0 only after read as 1.
// RQ21: software accesses the base register only as word or longword.
// RQ22: software enables on-chip ram before using the controller.
// RQ23: chain bit set fetches next consecutive descriptor and transfers again.
// RQ24: cpu interrupt when count completes or after a per-transfer-irq transfer.
// ----------------------------------------------------------------------
`ifndef RDTC_REGS_SVH
`define RDTC_REGS_SVH
// ----------------------------------------------------------------------
// apb offsets
// ----------------------------------------------------------------------
`define RDTC_OFS_EN_A 8'h00
`define RDTC_OFS_EN_B 8'h04
`define RDTC_OFS_EN_C 8'h08
`define RDTC_OFS_EN_D 8'h0c
`define RDTC_OFS_CSR 8'h10
`define RDTC_OFS_BASE 8'h14
// ----------------------------------------------------------------------
// control/status fields and reset values
// ----------------------------------------------------------------------
`define RDTC_CSR_VEC_LSB 0
`define RDTC_CSR_SWACT 8
`define RDTC_CSR_AE 9
`define RDTC_CSR_NMI_ABORT_FLAG 10
`define RDTC_CSR_RST 16'h0000
`define RDTC_BASE_RST 16'h0000
`define RDTC_EN_RST 28'h0000000
// ----------------------------------------------------------------------
// mode word fields
// ----------------------------------------------------------------------
`define RDTC_MD_SM 15:14
`define RDTC_MD_DM 13:12
`define RDTC_MD_MODE 11:10
`define RDTC_MD_DTS 9
`define RDTC_MD_CHAIN_ENABLE 8
`define RDTC_MD_PER_TRANSFER_IRQ_SELECT 7
`define RDTC_MD_SZ 5:4
// ----------------------------------------------------------------------
// memory layout
// ----------------------------------------------------------------------
`define RDTC_VEC_BASE 32'h00000400
`define RDTC_DESC_STEP 32'h00000010
`endif

// *** rdtc_pkg.sv ***
// types shared by the transfer controller
`default_nettype none
package rdtc_pkg;
	localparam int NSRC = 28;
	typedef enum logic [12:0]
	{
		RDTC_IDLE = 13'h0001,
		RDTC_VEC = 13'h0002,
		RDTC_D0 = 13'h0004,
		RDTC_D1 = 13'h0008,
		RDTC_D2 = 13'h0010,
		RDTC_D3 = 13'h0020,
		RDTC_RD = 13'h0040,
		RDTC_WR = 13'h0080,
		RDTC_WB0 = 13'h0100,
		RDTC_WB1 = 13'h0200,
		RDTC_WB2 = 13'h0400,
		RDTC_WB3 = 13'h0800,
		RDTC_FIN = 13'h1000
	} rdtc_state_t;
	typedef enum logic [1:0]
	{
		RDTC_NORMAL = 2'h0,
		RDTC_REPEAT = 2'h1,
		RDTC_BLOCK = 2'h2
	} rdtc_mode_t;
	typedef struct packed
	{
		rdtc_state_t st;
		logic [27:0] en;
		logic swact, swact_seen, sw_end, ae, ae_seen, nmi_abort_flag, nmi_abort_flag_seen;
		logic [7:0] vec;
		logic [15:0] base;
		logic pready, pslverr;
		logic [31:0] prdata;
		logic mem_req, mem_we;
		logic [1:0] mem_size;
		logic [31:0] mem_addr, mem_wdata;
		logic [15:0] mode, cnt_a, blk_cnt;
		logic [31:0] word1, sar, dar, blk_start, ptr, data;
		logic [4:0] idx;
		logic sw_act, vsel, want_irq;
		logic [27:0] flag_clr, cpu_irq;
	} rdtc_regs_t;
endpackage
`default_nettype wire

// *** rdtc_mem.sv ***
// behavioural on-chip ram answering the controller's memory master
`timescale 1ns/10ps
`default_nettype none
module rdtc_mem
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// memory slave port
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [1:0] mem_size,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	// bench control and status
	input wire logic [3:0] delay,
	output logic [7:0] writes
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	// bit 16 picks the page, so a wrong base reads the wrong words
	logic [31:0] ram [0:511];
	logic [8:0] idx;
	logic [3:0] cnt;
	logic gap;
	assign idx = {mem_addr[16], mem_addr[9:2]};
	// ----------------------------------------------------------------
	// access timing
	// ----------------------------------------------------------------
	// ram always enabled; longwords only, size not decoded
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'h00000000;
			cnt <= 4'h0;
			gap <= 1'b0;
			writes <= 8'h00;
		end
		else if (mem_ack)
		begin
			// released data is inverted so nothing relies on it
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			gap <= 1'b1;
			cnt <= 4'h0;
			if (mem_we)
			begin
				ram[idx] <= mem_wdata;
				writes <= writes + 8'h01;
			end
		end
		else if (!mem_req)
			gap <= 1'b0;
		else if (!gap && cnt != delay)
			cnt <= cnt + 4'h1;
		else if (!gap)
		begin
			mem_ack <= 1'b1;
			mem_rdata <= mem_we ? ~mem_rdata : ram[idx];
		end
	end
endmodule
`default_nettype wire

// *** rdtc_ctrl_bench.sv ***
// self-checking bench for the descriptor transfer controller
`timescale 1ns/10ps
`default_nettype none
module rdtc_ctrl_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic mem_req;
	logic mem_we;
	logic [1:0] mem_size;
	logic [31:0] mem_addr;
	logic [31:0] mem_wdata;
	logic mem_ack;
	logic [31:0] mem_rdata;
	logic [27:0] src_irq = 28'h0000000;
	logic [27:0] raise = 28'h0000000;
	logic nmi_abort = 1'b0;
	logic [27:0] src_flag_clear;
	logic [27:0] cpu_irq_req;
	logic sw_end_irq;
	logic [3:0] mdelay = 4'h0;
	logic [7:0] wr_cnt;
	int fail_count = 0;
	int checks_done = 0;
	rdtc_ctrl u_rdtc_ctrl
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_size,
		.mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .src_irq,
		.nmi_abort, .src_flag_clear, .cpu_irq_req, .sw_end_irq
	);
	rdtc_mem u_rdtc_mem
	(
		.pclk, .presetn, .mem_req, .mem_we, .mem_size, .mem_addr,
		.mem_wdata, .mem_ack, .mem_rdata, .delay(mdelay), .writes(wr_cnt)
	);
	initial
	begin
		forever #5 pclk = ~pclk;
	end
	// peripheral flags: raised by the bench, dropped by the clear pulse
	always @(posedge pclk)
		src_irq <= (src_irq | raise) & ~src_flag_clear;
	// every scenario moves longwords, so each access is one
	always @(posedge pclk)
		if (mem_req && mem_ack)
			chk({30'h0, mem_size}, 32'h00000002);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 40);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 40)
		begin
			fail_count++;
			wrap_up();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h00000000, r, e);
		chk(r, exp);
		chk({31'h0, e}, {31'h0, a > 8'h14});
	endtask
	function automatic logic [8:0] ix(input logic [31:0] a);
		return {a[16], a[9:2]};
	endfunction
	function automatic logic [31:0] dv(input int i);
		return 32'hc0de0000 + 32'(i);
	endfunction
	// descriptors and data stay longword aligned
	task automatic dsc(input logic [31:0] a, w0, w1, s, d);
		u_rdtc_mem.ram[ix(a)] = w0;
		u_rdtc_mem.ram[ix(a + 32'h4)] = w1;
		u_rdtc_mem.ram[ix(a + 32'h8)] = s;
		u_rdtc_mem.ram[ix(a + 32'hc)] = d;
	endtask
	task automatic mchk(input logic [31:0] a, input logic [31:0] exp);
		chk(u_rdtc_mem.ram[ix(a)], exp);
	endtask
	task automatic dchk(input logic [31:0] a, w0, s, d);
		chk(u_rdtc_mem.ram[ix(a)], w0);
		chk(u_rdtc_mem.ram[ix(a + 32'h8)], s);
		chk(u_rdtc_mem.ram[ix(a + 32'hc)], d);
	endtask
	// no idle flag at the ports, so settle a few cycles after writes
	task automatic run(input logic [27:0] v, input logic [7:0] n);
		int t;
		logic [7:0] goal;
		goal = wr_cnt + n;
		raise <= v;
		@(posedge pclk);
		raise <= 28'h0000000;
		t = 0;
		while (wr_cnt !== goal && t < 3000)
		begin
			@(posedge pclk);
			t++;
		end
		repeat (6) @(posedge pclk);
		if (t >= 3000)
		begin
			fail_count++;
			wrap_up();
		end
	endtask
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int a = 0; a <= 24; a += 4)
			rd(8'(a), 32'h00000000);
		wr(8'h0c, 32'h000000ff);
		rd(8'h0c, 32'h000000f0);
		wr(8'h0c, 32'h00000000);
		wr(8'h14, 32'h00000001);
		rd(8'h14, 32'h00000001);
		for (int i = 0; i < 4; i++)
			u_rdtc_mem.ram[ix(32'h00010300 + 32'(4 * i))] = dv(i);
		u_rdtc_mem.ram[0] = 32'h01000140;
		u_rdtc_mem.ram[1] = 32'h018001c0;
		u_rdtc_mem.ram[4] = 32'h02400000;
		u_rdtc_mem.ram[8] = 32'h02000000;
		// normal mode, two activations
		dsc(32'h00010100, 32'ha0200002, 32'h0, 32'h00010300, 32'h00010380);
		wr(8'h00, 32'h00000080);
		run(28'h0000001, 8'h05);
		mchk(32'h00010380, dv(0));
		dchk(32'h00010100, 32'ha0200001, 32'h00010304, 32'h00010384);
		chk({4'h0, src_irq}, 32'h00000000);
		rd(8'h00, 32'h00000080);
		run(28'h0000001, 8'h05);
		mchk(32'h00010384, dv(1));
		dchk(32'h00010100, 32'ha0200000, 32'h00010308, 32'h00010388);
		rd(8'h00, 32'h00000000);
		chk({4'h0, cpu_irq_req}, 32'h00000001);
		// two sources at once, slow memory
		mdelay <= 4'h2;
		dsc(32'h00010140, 32'ha0200001, 32'h0, 32'h00010300, 32'h00010390);
		dsc(32'h00010180, 32'ha0200001, 32'h0, 32'h00010308, 32'h00010390);
		wr(8'h00, 32'h00000060);
		run(28'h0000006, 8'h0a);
		mchk(32'h00010390, dv(2));
		chk({4'h0, cpu_irq_req}, 32'h00000007);
		// block mode, spare bytes all ones
		dsc(32'h000101c0, 32'haa200001, 32'hffff0002, 32'h00010300,
			32'h000103a0);
		wr(8'h00, 32'h00000010);
		run(28'h0000008, 8'h06);
		mchk(32'h000103a0, dv(0));
		mchk(32'h000103a4, dv(1));
		dchk(32'h000101c0, 32'haa200000, 32'h00010300, 32'h000103a8);
		chk({16'h0, u_rdtc_mem.ram[ix(32'h000101c4)][15:0]}, 32'h2);
		chk({4'h0, cpu_irq_req}, 32'h0000000f);
		// repeat mode, wrap of the low count byte
		mdelay <= 4'h0;
		dsc(32'h00010240, 32'ha6200101, 32'h00010300, 32'h00010304,
			32'h000103b0);
		wr(8'h04, 32'h00000080);
		run(28'h0000100, 8'h05);
		mchk(32'h000103b0, dv(1));
		dchk(32'h00010240, 32'ha6200101, 32'h00010300, 32'h000103b4);
		chk({4'h0, src_irq}, 32'h0000000f);
		rd(8'h04, 32'h00000080);
		// software activation of a two-link chain
		mdelay <= 4'h3;
		dsc(32'h00010200, 32'ha1200002, 32'h0, 32'h00010308, 32'h000103c0);
		dsc(32'h00010210, 32'ha0200001, 32'h0, 32'h0001030c, 32'h000103c4);
		wr(8'h10, 32'h00000120);
		run(28'h0000000, 8'h0a);
		mchk(32'h000103c0, dv(2));
		mchk(32'h000103c4, dv(3));
		dchk(32'h00010200, 32'ha1200001, 32'h0001030c, 32'h000103c4);
		chk({31'h0, sw_end_irq}, 32'h00000001);
		wr(8'h10, 32'h00000000);
		rd(8'h10, 32'h00000100);
		wr(8'h10, 32'h00000000);
		rd(8'h10, 32'h00000000);
		chk({31'h0, sw_end_irq}, 32'h00000000);
		// abort flag clearing
		nmi_abort <= 1'b1;
		@(posedge pclk);
		nmi_abort <= 1'b0;
		wr(8'h10, 32'h00000000);
		rd(8'h10, 32'h00000400);
		wr(8'h10, 32'h00000400);
		rd(8'h10, 32'h00000400);
		wr(8'h10, 32'h00000000);
		rd(8'h10, 32'h00000000);
		wrap_up();
	end
endmodule
`default_nettype wire
